// ==== hdl/sfc_flash_ctrl.sv ====
/*
  serial flash controller: automatic fast reads (single or dual lane) for the
  processor's external data space, a 32-byte pipeline cache, and a buffered
  command mode steered over apb.
  assumes pclk at 40 MHz, flash pins outside the clock domain, and a processor
  that raises external_data_space_rd for one cycle per read and waits for external_data_space_ready.
*/
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps

module sfc_flash_ctrl import sfc_pkg::*; #(
  parameter int HALF_CLKS = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor external data space reads
  input wire logic external_data_space_rd,
  input wire logic [SFC_ADDR_W-1:0] external_data_space_addr,
  output logic external_data_space_ready,
  output logic [7:0] external_data_space_rdata,
  // serial flash pins
  output logic flash_sel_n,
  output logic flash_sck,
  output logic flash_io0_o,
  output logic flash_io0_oe_n,
  input wire logic flash_io0_i,
  input wire logic serial_in_line
);

  typedef struct packed {
    sfc_state_e st;
    logic [7:0] div;
    logic sck;
    logic sel_n;
    logic io0;
    logic io0_oe_n;
    logic [31:0] sh;
    logic [5:0] bits;
    logic [SFC_LEN_W-1:0] nbyte;
    logic [7:0] rx;
    logic [SFC_ADDR_W-1:0] last;
    logic pend;
    logic [SFC_ADDR_W-1:0] pend_addr;
    logic [SFC_CACHE_BYTES-1:0][7:0] cache;
    logic [SFC_ADDR_W-1:0] base;
    logic [5:0] clen;
    logic rdy;
    logic [7:0] rdata;
    logic go;
    logic dual;
    logic [7:0] opcode;
    logic [SFC_LEN_W-1:0] len;
    logic disable_if;
    logic [SFC_BUF_BYTES-1:0][7:0] cmdbuf;
    logic [SFC_BUF_BYTES-1:0][7:0] rspbuf;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic d0_m;
    logic d0_s;
    logic di_m;
    logic di_s;
  } sfc_state_s;

  localparam logic [7:0] HALF_TERM = 8'(HALF_CLKS - 1);
  localparam logic [5:0] CACHE_FULL = 6'(SFC_CACHE_BYTES);

  sfc_state_s q, d;

  // address falls inside the bytes held in the cache
  // wrap-around subtraction keeps the range test to one comparator
  function automatic logic cache_hit(input logic [SFC_ADDR_W-1:0] a, input logic [SFC_ADDR_W-1:0] b,
                                     input logic [5:0] n);
    logic [SFC_ADDR_W-1:0] off;
    off = a - b;
    return off < {{(SFC_ADDR_W-6){1'b0}}, n};
  endfunction

  // register read decode; unmapped offsets flag an error
  function automatic logic [32:0] reg_read(input sfc_state_s s, input logic [7:0] a);
    logic [32:0] r;
    r = '0;
    case (a)
      SFC_OFF_CTRL: r[31:0] = {30'h0, s.dual, s.go};
      SFC_OFF_OPCODE: r[31:0] = {24'h0, s.opcode};
      SFC_OFF_LEN: r[31:0] = {28'h0, s.len};
      SFC_OFF_UTIL: r[31:0] = {31'h0, s.disable_if};
      SFC_OFF_CMD_LO: r[31:0] = s.cmdbuf[3:0];
      SFC_OFF_CMD_HI: r[31:0] = s.cmdbuf[7:4];
      SFC_OFF_RSP_LO: r[31:0] = s.rspbuf[3:0];
      SFC_OFF_RSP_HI: r[31:0] = s.rspbuf[7:4];
      SFC_OFF_STATUS: r[31:0] = {20'h0, s.clen, 3'h0, s.st};
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction

  // start a flash read after a jump; cache restarts at this address
  function automatic sfc_state_s start_read(input sfc_state_s s, input logic [SFC_ADDR_W-1:0] a);
    sfc_state_s n;
    n = s;
    n.st = ST_ADDR;
    n.sel_n = 1'b0;
    n.sh = {s.opcode, SFC_ZERO_ADDR_HI, a};
    n.io0 = s.opcode[7];
    n.io0_oe_n = 1'b0;
    n.bits = SFC_HDR_BITS;
    n.div = '0;
    n.sck = 1'b0;
    n.last = a;
    n.base = a;
    n.clen = '0;
    return n;
  endfunction

  logic [32:0] rd_word;
  logic [7:0] rx_next;
  logic [SFC_LEN_W-1:0] nb_inc;
  logic tick_fall;
  logic hit_req;
  logic go_set;

  always_comb begin
    d = q;
    d.rdy = 1'b0;
    rd_word = reg_read(q, paddr);
    hit_req = cache_hit(external_data_space_addr, q.base, q.clen);
    nb_inc = q.nbyte + 1'b1;
    // two-lane capture takes the io0 line as the high bit of each pair
    rx_next = q.dual ? {q.rx[5:0], q.d0_s, q.di_s} : {q.rx[6:0], q.di_s};
    tick_fall = 1'b0;
    go_set = 1'b0;

    // pin synchronisers; only the second stage is read below
    d.d0_m = flash_io0_i;
    d.d0_s = q.d0_m;
    d.di_m = serial_in_line;
    d.di_s = q.di_m;

    // apb: answer in the first access cycle, write lands at that edge
    d.pready = 1'b0;
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.prdata = pwrite ? 32'h0 : rd_word[31:0];
      d.pslverr = rd_word[32];
    end
    if (psel && penable && q.pready && pwrite && !rd_word[32]) begin
      case (paddr)
        SFC_OFF_CTRL: begin
          d.dual = pwdata[SFC_CTRL_DUAL];
          if (pwdata[SFC_CTRL_GO] && !q.disable_if) begin
            d.go = 1'b1;
            go_set = 1'b1;
          end
        end
        SFC_OFF_OPCODE: d.opcode = pwdata[7:0];
        SFC_OFF_LEN: d.len = pwdata[SFC_LEN_W-1:0];
        SFC_OFF_UTIL: d.disable_if = pwdata[SFC_UTIL_DISABLE];
        SFC_OFF_CMD_LO: d.cmdbuf[3:0] = pwdata;
        SFC_OFF_CMD_HI: d.cmdbuf[7:4] = pwdata;
        default: d.pslverr = q.pslverr;
      endcase
    end

    // serial clock divider: rise after one half period, fall after the next
    if (q.st inside {ST_ADDR, ST_DUMMY, ST_DATA, ST_XFER}) begin
      if (q.div == HALF_TERM) begin
        d.div = '0;
        d.sck = ~q.sck;
        tick_fall = q.sck;
      end else begin
        d.div = q.div + 8'h01;
      end
    end

    case (q.st)
      // idle: reads go first, a waiting command after them
      ST_IDLE: begin
        d.sel_n = 1'b1;
        d.io0_oe_n = 1'b0;
        if (q.pend || external_data_space_rd) begin
          d.pend = 1'b0;
          if (q.disable_if) begin
            d.rdy = 1'b1;
            d.rdata = SFC_DISABLED_DATA;
          end else if (cache_hit(q.pend ? q.pend_addr : external_data_space_addr, q.base, q.clen)) begin
            d.rdy = 1'b1;
            d.rdata = q.cache[q.pend ? q.pend_addr[4:0] : external_data_space_addr[4:0]];
          end else begin
            d = start_read(d, q.pend ? q.pend_addr : external_data_space_addr);
          end
        end else if (q.go) begin
          if (q.len == '0) begin
            // a go landing this very cycle outlives the clear
            d.go = go_set;
          end else begin
            d.st = ST_XFER;
            d.sel_n = 1'b0;
            d.sh = {q.cmdbuf[0], 24'h0};
            d.io0 = q.cmdbuf[0][7];
            d.bits = SFC_BYTE_BITS;
            d.nbyte = '0;
            d.div = '0;
            d.sck = 1'b0;
          end
        end
      end
      // header: opcode and address leave msb first on falling edges
      ST_ADDR: if (tick_fall) begin
        d.sh = {q.sh[30:0], 1'b0};
        d.io0 = q.sh[30];
        d.bits = q.bits - 6'h01;
        if (q.bits == 6'h01) begin
          d.st = ST_DUMMY;
          d.bits = SFC_BYTE_BITS;
          d.io0 = 1'b0;
        end
      end
      // dummy byte; io0 released at its end in dual mode
      ST_DUMMY: if (tick_fall) begin
        d.bits = q.bits - 6'h01;
        if (q.bits == 6'h01) begin
          d.st = ST_DATA;
          d.bits = q.dual ? SFC_DUAL_CLKS : SFC_BYTE_BITS;
          d.io0_oe_n = q.dual;
        end
      end
      // data: capture on falling edges, answer and fill cache at the end
      ST_DATA: if (tick_fall) begin
        d.rx = rx_next;
        d.bits = q.bits - 6'h01;
        if (q.bits == 6'h01) begin
          d.st = ST_HOLD;
          d.rdy = 1'b1;
          d.rdata = rx_next;
          d.cache[q.last[4:0]] = rx_next;
          if (q.clen == CACHE_FULL) begin
            d.base = q.base + 1'b1;
          end else begin
            d.clen = q.clen + 6'h01;
          end
        end
      end
      ST_HOLD: if (external_data_space_rd) begin
        // select stays low between sequential bytes, clock parked low
        if (external_data_space_addr == q.last + 1'b1 && !q.disable_if) begin
          d.st = ST_DATA;
          d.last = external_data_space_addr;
          d.bits = q.dual ? SFC_DUAL_CLKS : SFC_BYTE_BITS;
          d.div = '0;
        end else if (hit_req && !q.disable_if) begin
          d.st = ST_CSHI;
          d.sel_n = 1'b1;
          d.rdy = 1'b1;
          d.rdata = q.cache[external_data_space_addr[4:0]];
        end else begin
          d.st = ST_CSHI;
          d.sel_n = 1'b1;
          d.pend = 1'b1;
          d.pend_addr = external_data_space_addr;
        end
      end else if (q.go || q.disable_if) begin
        // a waiting command or a disable closes the open stream
        d.st = ST_CSHI;
        d.sel_n = 1'b1;
      end
      // buffered command: shift out and capture one byte per eight falls
      ST_XFER: if (tick_fall) begin
        d.rx = {q.rx[6:0], q.di_s};
        d.sh = {q.sh[30:0], 1'b0};
        d.io0 = q.sh[30];
        d.bits = q.bits - 6'h01;
        if (q.bits == 6'h01) begin
          if (q.nbyte != '0 && q.nbyte <= SFC_LEN_W'(SFC_BUF_BYTES)) begin
            d.rspbuf[3'(q.nbyte - 1'b1)] = {q.rx[6:0], q.di_s};
          end
          d.nbyte = nb_inc;
          d.bits = SFC_BYTE_BITS;
          if (nb_inc == q.len) begin
            d.st = ST_CSHI;
            d.sel_n = 1'b1;
          end else begin
            d.sh[31:24] = (nb_inc < SFC_LEN_W'(SFC_BUF_BYTES)) ? q.cmdbuf[3'(nb_inc)] : SFC_FILL_BYTE;
            d.io0 = (nb_inc < SFC_LEN_W'(SFC_BUF_BYTES)) ? q.cmdbuf[3'(nb_inc)][7] : SFC_FILL_BYTE[7];
          end
        end
      end
      ST_CSHI: begin
        // select high for two half periods before anything new starts
        d.sel_n = 1'b1;
        // the last byte was already answered, so the processor may strobe
        // again here; park the request instead of losing it
        if (external_data_space_rd) begin
          d.pend = 1'b1;
          d.pend_addr = external_data_space_addr;
        end
        d.io0_oe_n = 1'b0;
        d.sck = 1'b0;
        if (q.div == HALF_TERM + HALF_TERM + 8'h01) begin
          d.div = '0;
          d.st = ST_IDLE;
          if (q.nbyte == q.len && q.go) begin
            // a new go write in the same cycle wins over the self-clear
            d.go = go_set;
            d.nbyte = '0;
          end
        end else begin
          d.div = q.div + 8'h01;
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // io0 is taken back whenever select is high, so a dual stream that is
    // closed mid-way never leaves the line floating between frames
    if (d.sel_n) begin
      d.io0_oe_n = 1'b0;
    end
  end

  // single state register; the cache and buffers ride in it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.sel_n <= 1'b1;
      q.opcode <= SFC_OPCODE_RST;
      q.len <= SFC_LEN_RST;
    end else begin
      q <= d;
    end
  end

  // every output straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign external_data_space_ready = q.rdy;
  assign external_data_space_rdata = q.rdata;
  assign flash_sel_n = q.sel_n;
  assign flash_sck = q.sck;
  assign flash_io0_o = q.io0;
  assign flash_io0_oe_n = q.io0_oe_n;

endmodule

// ==== shared/sfc_pkg.sv ====
/*
  shared constants for the serial flash read/command controller: register map,
  field positions, reset values, opcodes, state encoding.
  assumes a 32-bit apb register bus and a byte-wide processor read port.
*/
package sfc_pkg;

  // apb register byte offsets
  localparam logic [7:0] SFC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SFC_OFF_OPCODE = 8'h04;
  localparam logic [7:0] SFC_OFF_LEN = 8'h08;
  localparam logic [7:0] SFC_OFF_UTIL = 8'h0C;
  localparam logic [7:0] SFC_OFF_CMD_LO = 8'h10;
  localparam logic [7:0] SFC_OFF_CMD_HI = 8'h14;
  localparam logic [7:0] SFC_OFF_RSP_LO = 8'h18;
  localparam logic [7:0] SFC_OFF_RSP_HI = 8'h1C;
  localparam logic [7:0] SFC_OFF_STATUS = 8'h20;

  // field positions
  localparam int SFC_CTRL_GO = 0;
  localparam int SFC_CTRL_DUAL = 1;
  localparam int SFC_UTIL_DISABLE = 0;
  localparam int SFC_LEN_W = 4;
  localparam int SFC_ADDR_W = 17;

  // reset values
  localparam logic [7:0] SFC_OPCODE_RST = 8'h0B;
  localparam logic [SFC_LEN_W-1:0] SFC_LEN_RST = 4'h0;

  // flash opcodes that firmware loads for the documented command shapes
  localparam logic [7:0] SFC_OP_FAST_READ = 8'h0B;
  localparam logic [7:0] SFC_OP_DUAL_READ = 8'h3B;
  localparam logic [7:0] SFC_OP_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] SFC_OP_SMALL_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] SFC_OP_LARGE_BLOCK_WIPE = 8'hD8;
  localparam logic [7:0] SFC_OP_BYTE_PROGRAM = 8'h02;
  localparam logic [7:0] SFC_OP_READ_ID = 8'h9F;

  // serial frame shapes
  localparam logic [5:0] SFC_HDR_BITS = 6'h20;
  localparam logic [5:0] SFC_BYTE_BITS = 6'h08;
  localparam logic [5:0] SFC_DUAL_CLKS = 6'h04;
  localparam logic [6:0] SFC_ZERO_ADDR_HI = 7'h00;
  localparam int SFC_CACHE_BYTES = 32;
  localparam int SFC_BUF_BYTES = 8;
  localparam logic [7:0] SFC_FILL_BYTE = 8'h00;
  localparam logic [7:0] SFC_DISABLED_DATA = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_DUMMY, ST_DATA, ST_HOLD, ST_CSHI, ST_XFER
  } sfc_state_e;

endpackage

// ==== sim/sfc_flash_ctrl_asserts.sv ====
/*
  port checker for the flash controller.
  assumes it is bound into every controller instance.
*/
`timescale 1ns/1ps
module sfc_flash_ctrl_asserts #(
  parameter int HALF_CLKS = 2
) (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // processor and flash pins
  input wire logic external_data_space_rd,
  input wire logic external_data_space_ready,
  input wire logic flash_sel_n,
  input wire logic flash_sck,
  input wire logic flash_io0_o,
  input wire logic flash_io0_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // the two apb phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_apb_zero_wait: assert property (s_setup |=> s_access) else $error("pready late");
  a_apb_err_map: assert property (s_setup ##1 s_access |-> pslverr == (paddr > 8'h20 || paddr[1:0] != 2'b00))
    else $error("pslverr wrong");
  a_ready_pulse: assert property (external_data_space_ready |=> !external_data_space_ready) else $error("ready too long");
  a_read_answer: assert property (external_data_space_rd && flash_sel_n |-> ##[1:700] external_data_space_ready)
    else $error("read unanswered");
  a_sck_idle_low: assert property (flash_sel_n |-> !flash_sck) else $error("sck outside frame");
  a_sck_half_len: assert property ($rose(flash_sck) |-> ##HALF_CLKS $fell(flash_sck))
    else $error("sck half period");
  // io0 moves only on a falling sck while the frame runs
  a_io0_on_fall: assert property (!flash_sel_n && $past(!flash_sel_n) && !flash_io0_oe_n
    && $changed(flash_io0_o) |-> $fell(flash_sck)) else $error("io0 moved off edge");
  a_oe_in_frame: assert property (flash_io0_oe_n |-> !flash_sel_n) else $error("io0 released idle");
endmodule

bind sfc_flash_ctrl sfc_flash_ctrl_asserts #(.HALF_CLKS(HALF_CLKS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .external_data_space_rd(external_data_space_rd), .external_data_space_ready(external_data_space_ready),
  .flash_sel_n(flash_sel_n), .flash_sck(flash_sck), .flash_io0_o(flash_io0_o),
  .flash_io0_oe_n(flash_io0_oe_n));

// ==== sim/sfc_flash_model.sv ====
/*
  behavioural serial flash: single and dual fast read, id read, and a
  record of the bytes shifted in during the latest frame.
  assumes mode 0 clocking from the controller.
*/
`timescale 1ns/1ps
module sfc_flash_model (
  // flash pins
  input wire logic sel_n,
  input wire logic sck,
  input wire logic io0,
  output logic so,
  output logic io0_drv
);
  localparam logic [23:0] ID_CODE = 24'h5AC371; // arbitrary id value
  logic [7:0] sh, op, ob;
  logic [23:0] adr;
  logic [7:0] rx_q[$];
  int bits, frames, k;
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3C;
  endfunction
  initial begin
    so = 1'b0;
    io0_drv = 1'b0;
    bits = 0;
    frames = 0;
  end
  // a new frame clears the record
  always @(negedge sel_n) begin
    bits = 0;
    op = 8'h00;
    frames++;
    rx_q.delete();
  end
  // released lines must not keep their last level
  always @(posedge sel_n) begin
    so = ~so;
    io0_drv = ~io0_drv;
  end
  // shift in on rising sck
  always @(posedge sck) if (!sel_n) begin
    sh = {sh[6:0], io0};
    bits++;
    if (bits > 8 && bits <= 32) adr = {adr[22:0], io0};
    if (bits == 8) op = sh;
    if (bits % 8 == 0) rx_q.push_back(sh);
  end
  // drive on falling sck, first data bit after the dummy byte
  always @(negedge sck) if (!sel_n) begin
    k = bits - 40;
    if (op == 8'h0B && k >= 0) begin
      ob = mem(adr + 24'(k / 8));
      so = ob[7 - k % 8];
    end else if (op == 8'h3B && k >= 0) begin
      ob = mem(adr + 24'(k / 4));
      so = ob[6 - 2 * (k % 4)];
    end else if (op == 8'h9F && bits >= 8 && bits < 32) so = ID_CODE[31 - bits];
    else so = ~so;
    if (op == 8'h3B && k >= 0) io0_drv = ob[7 - 2 * (k % 4)];
    else io0_drv = ~io0_drv;
  end
endmodule

// ==== sim/tb_top.sv ====
/*
  bench for the flash controller: apb and processor drivers, flash model.
  assumes 40 MHz pclk and a 200 ns flash clock from HALF_CLKS of 4.
*/
`timescale 1ns/1ps
module tb_top;
  import sfc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, external_data_space_rd, external_data_space_ready, e;
  logic flash_sel_n, flash_sck, flash_io0_o, flash_io0_oe_n, io0_drv, serial_in_line;
  logic [7:0] paddr, external_data_space_rdata, d;
  logic [31:0] pwdata, prdata, r;
  logic [16:0] external_data_space_addr, a;
  logic [63:0] cmd;
  logic [7:0] ops [7] = '{8'h9F, 8'h20, 8'h52, 8'hD8, 8'h02, 8'h06, 8'h05};
  int lens [7] = '{4, 4, 4, 4, 5, 1, 9};
  int fail_count, comparisons, cycles, cyc, seed, f0, i, k;
  wire io0_wire = flash_io0_oe_n ? io0_drv : flash_io0_o; // oe_n high hands io0 to flash
  sfc_flash_ctrl #(.HALF_CLKS(4)) i_sfc_flash_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_data_space_rd(external_data_space_rd), .external_data_space_addr(external_data_space_addr),
    .external_data_space_ready(external_data_space_ready), .external_data_space_rdata(external_data_space_rdata), .flash_sel_n(flash_sel_n),
    .flash_sck(flash_sck), .flash_io0_o(flash_io0_o), .flash_io0_oe_n(flash_io0_oe_n),
    .flash_io0_i(io0_wire), .serial_in_line(serial_in_line));
  sfc_flash_model u_flash (.sel_n(flash_sel_n), .sck(flash_sck), .io0(io0_wire),
    .so(serial_in_line), .io0_drv(io0_drv));
  // flash contents as the bench expects them
  function automatic logic [7:0] exp_mem(input logic [16:0] x);
    return x[7:0] ^ x[15:8] ^ {7'h00, x[16]} ^ 8'h3C;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    if (pready !== 1'b1) chk("apb_ready", 1, pready);
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one processor read; cyc counts edges up to the answer
  task automatic xrd(input logic [16:0] ad);
    @(posedge pclk);
    external_data_space_rd <= 1'b1;
    external_data_space_addr <= ad;
    @(posedge pclk);
    external_data_space_rd <= 1'b0;
    cyc = 1;
    while (external_data_space_ready !== 1'b1 && cyc < 2000) begin
      @(posedge pclk);
      cyc++;
    end
    if (external_data_space_ready !== 1'b1) chk("xrd_ready", 1, external_data_space_ready);
    d = external_data_space_rdata;
  endtask
  task automatic hdr(input logic [7:0] op, input logic [16:0] x);
    chk("hdr_op", op, u_flash.rx_q[0]);
    chk("hdr_addr", {7'h00, x}, {u_flash.rx_q[1], u_flash.rx_q[2], u_flash.rx_q[3]});
  endtask
  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 60000) begin
      fail_count++;
      close_out;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, external_data_space_rd, paddr, pwdata, external_data_space_addr} = '0;
    seed = 26;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SFC_OFF_OPCODE, 32'h0);
    chk("opcode_rst", 32'h0B, r);
    apb(1'b0, SFC_OFF_LEN, 32'h0);
    chk("len_rst", 32'h0, r);
    apb(1'b0, SFC_OFF_UTIL, 32'h0);
    chk("util_rst", 32'h0, r);
    apb(1'b1, 8'h24, 32'hFFFF);
    chk("unmapped", 1, e);
    $display("test registers done");
    a = 17'($random(seed));
    a[16] = 1'b0; // keeps the 34-byte run clear of the top of the space
    xrd(a);
    chk("rd_data", exp_mem(a), d);
    hdr(8'h0B, a);
    f0 = u_flash.frames;
    for (i = 1; i < 34; i++) begin
      xrd(a + 17'(i));
      chk("seq_data", exp_mem(a + 17'(i)), d);
    end
    chk("seq_fast", 1, cyc < 100);
    chk("seq_frames", f0, u_flash.frames);
    xrd(a + 17'd10);
    chk("hit_data", exp_mem(a + 17'd10), d);
    chk("hit_cycles", 2, cyc);
    chk("hit_frames", f0, u_flash.frames);
    xrd(a + 17'd1);
    chk("evict_miss", 1, cyc > 100);
    chk("evict_data", exp_mem(a + 17'd1), d);
    hdr(8'h0B, a + 17'd1);
    $display("test single lane done");
    apb(1'b1, SFC_OFF_OPCODE, 32'h3B);
    apb(1'b1, SFC_OFF_CTRL, 32'h2);
    a = 17'($random(seed));
    xrd(a);
    chk("dual_data", exp_mem(a), d);
    hdr(8'h3B, a);
    xrd(a + 17'd1);
    chk("dual_seq", exp_mem(a + 17'd1), d);
    chk("dual_four_clks", 1, cyc < 50);
    $display("test dual lane done");
    apb(1'b1, SFC_OFF_CTRL, 32'h0);
    for (i = 0; i < 7; i++) begin
      cmd = {32'($random(seed)), 24'($random(seed)), ops[i]};
      apb(1'b1, SFC_OFF_CMD_LO, cmd[31:0]);
      apb(1'b1, SFC_OFF_CMD_HI, cmd[63:32]);
      apb(1'b1, SFC_OFF_LEN, 32'(lens[i]));
      f0 = u_flash.frames;
      apb(1'b1, SFC_OFF_CTRL, 32'h1);
      apb(1'b0, SFC_OFF_CTRL, 32'h0);
      chk("go_busy", 1, r[0]);
      k = 0;
      while (r[0] !== 1'b0 && k < 300) begin
        apb(1'b0, SFC_OFF_CTRL, 32'h0);
        k++;
      end
      chk("go_clear", 0, r[0]);
      chk("cmd_frames", f0 + 1, u_flash.frames);
      chk("cmd_clocks", lens[i] * 8, u_flash.bits);
      for (k = 0; k < lens[i]; k++) begin
        chk("cmd_byte", k < 8 ? cmd[8 * k +: 8] : 8'h00, u_flash.rx_q[k]);
      end
      apb(1'b0, SFC_OFF_RSP_LO, 32'h0);
      if (i == 0) chk("id_bytes", 24'h71C35A, r[23:0]);
    end
    $display("test commands done");
    apb(1'b1, SFC_OFF_UTIL, 32'h1);
    f0 = u_flash.frames;
    xrd(a);
    chk("off_data", 8'hFF, d);
    chk("off_frames", f0, u_flash.frames);
    $display("test disable done");
    close_out;
  end
endmodule
